// ===== cwu_complementary_wave_unit.sv
`timescale 1ns/10ps
`default_nettype none

module cwu_complementary_wave_unit
    import cwu_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // waveform and shutdown sources (asynchronous)
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    input wire logic pulse_unit_one_output,
    input wire logic pulse_unit_two_output,
    input wire logic fault_input_pin_n,
    input wire logic internal_fast_oscillator,
    // output pins
    output logic drive_output_a,
    output logic drive_output_a_oe,
    output logic drive_output_b,
    output logic drive_output_b_oe
);

    cwu_state_t s_r;
    cwu_state_t s_nxt;

    // ----------------------------------------
    // operating notes
    // ----------------------------------------
    // every asynchronous level passes two flip-flops before use,
    // so an input edge is seen two cycles after it reaches the pin.
    // the comparator inputs share one synchroniser between the
    // waveform mux and the shutdown logic, so both see the same level.
    // the oscillator is sampled as data; its synced rising edge is
    // the count tick when the oscillator is chosen as counting clock.
    // the sampling clock must stay well above the oscillator rate,
    // otherwise oscillator edges are lost and dead time stretches.
    // edge sampling adds up to one counting clock of dead-time jitter.
    // the block keeps counting whenever sys_clk runs; nothing here
    // depends on a sleep signal, so sleep behaviour is up to the
    // clock tree keeping sys_clk alive.
    // dead time of n means the drive turns on n ticks after the
    // edge-capture cycle; n of zero switches in the capture cycle.
    // an opposite edge always wins over a pending count, so a
    // short pulse never turns the pending drive on.
    // shutdown and the hold of the overrides are two flags: the
    // status flag follows sources and software, the hold flag
    // keeps overrides on until a rising edge after status clears.
    // a set from an active source always beats a software clear.
    // with polarity set the pin equals the internal drive; with it
    // clear the pin is the inverse, except under overrides.

    // ----------------------------------------
    // helpers
    // ----------------------------------------

    // override level: polarity ignored except in the inactive setting, tri-state drops enable
    function automatic logic [1:0] ovr_pin(input logic [1:0] lvl, input logic act, input logic pol);
        case (lvl)
            CWU_LVL_HIGH: ovr_pin = 2'b11;
            CWU_LVL_LOW: ovr_pin = 2'b10;
            CWU_LVL_TRI: ovr_pin = 2'b00;
            default: ovr_pin = {1'b1, ~(act ^ pol)}; // inactive setting: follows the drive with polarity
        endcase
    endfunction

    // word address match; address bits 1:0 are ignored
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    logic in_sel;
    logic sd_act;
    logic tick;
    logic rise;
    logic fall;
    logic [1:0] pa;
    logic [1:0] pb;

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        // synchronisers for all asynchronous inputs
        s_nxt.src_s1 = {pulse_unit_two_output, pulse_unit_one_output};
        s_nxt.src_s2 = s_r.src_s1;
        s_nxt.sdin_s1 = {comparator_two_output, comparator_one_output, ~fault_input_pin_n};
        s_nxt.sdin_s2 = s_r.sdin_s1;
        s_nxt.osc_s1 = internal_fast_oscillator;
        s_nxt.osc_s2 = s_r.osc_s1;
        s_nxt.osc_d = s_r.osc_s2;

        // input source mux; comparators reuse the shutdown synchronisers
        case (s_r.ctrl1[CWU_C1_IS +: 2])
            CWU_SRC_C2: in_sel = s_r.sdin_s2[2];
            CWU_SRC_C1: in_sel = s_r.sdin_s2[1];
            CWU_SRC_P1: in_sel = s_r.src_s2[0];
            default: in_sel = s_r.src_s2[1];
        endcase

        // count tick: every sys_clk or each oscillator rising edge
        tick = s_r.ctrl0[CWU_C0_CS] ? (s_r.osc_s2 & ~s_r.osc_d) : 1'b1;
        rise = in_sel & ~s_r.in_d;
        fall = ~in_sel & s_r.in_d;
        s_nxt.in_d = in_sel;

        // external shutdown level
        sd_act = (s_r.ctrl2[1] & s_r.sdin_s2[2]) | (s_r.ctrl2[0] & s_r.sdin_s2[1])
               | (s_r.ctrl2[2] & s_r.sdin_s2[0]);

        // shutdown status: hardware set wins
        if (sd_act) begin
            s_nxt.sd_stat = 1'b1;
        end else if (s_r.ctrl2[3] && rise) begin
            s_nxt.sd_stat = 1'b0;
        end
        if (s_r.sd_stat || sd_act) begin
            s_nxt.hold = 1'b1;
        end else if (rise) begin
            s_nxt.hold = 1'b0;
        end

        // dead-band sequencer
        // the cycle after enable rises forces both drives off, so the
        // first waveform always starts from a cleared pair.
        // while disabled the drives are held off and the count is idle.
        // a rising edge turns b off at once and arms the rising count;
        // a falling edge turns a off at once and arms the falling count.
        // one shared counter serves both phases, since only one count
        // can be pending at a time; the phase names which one it is.
        // the counter runs from zero and compares its next value with
        // the programmed count, so it never wraps past the top value.
        // ticks are every sys_clk or each synced oscillator rise.
        // an edge in the same cycle as a tick takes priority and
        // restarts the count from zero.
        // writing a new count while one is pending takes effect on
        // the next compare, which may end the pending count early.
        // the override path does not stop the sequencer: drives keep
        // following the input so normal operation resumes cleanly.
        s_nxt.en_d = s_r.ctrl0[CWU_C0_EN];
        if (!s_r.ctrl0[CWU_C0_EN] || (s_r.ctrl0[CWU_C0_EN] && !s_r.en_d)) begin
            s_nxt.drv_a = 1'b0;
            s_nxt.drv_b = 1'b0;
            s_nxt.phase = CWU_ST_OFF;
            s_nxt.cnt = 6'h00;
        end else if (rise) begin
            s_nxt.drv_b = 1'b0;
            s_nxt.cnt = 6'h00;
            if (s_r.dbr == 6'h00) begin
                s_nxt.drv_a = 1'b1;
                s_nxt.phase = CWU_ST_OFF;
            end else begin
                s_nxt.drv_a = 1'b0;
                s_nxt.phase = CWU_ST_RISE;
            end
        end else if (fall) begin
            s_nxt.drv_a = 1'b0;
            s_nxt.cnt = 6'h00;
            if (s_r.dbf == 6'h00) begin
                s_nxt.drv_b = 1'b1;
                s_nxt.phase = CWU_ST_OFF;
            end else begin
                s_nxt.drv_b = 1'b0;
                s_nxt.phase = CWU_ST_FALL;
            end
        end else if (tick) begin
            case (s_r.phase)
                CWU_ST_RISE: begin
                    if (s_r.cnt + 6'h01 >= s_r.dbr) begin
                        s_nxt.drv_a = 1'b1;
                        s_nxt.phase = CWU_ST_OFF;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 6'h01;
                    end
                end
                CWU_ST_FALL: begin
                    if (s_r.cnt + 6'h01 >= s_r.dbf) begin
                        s_nxt.drv_b = 1'b1;
                        s_nxt.phase = CWU_ST_OFF;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 6'h01;
                    end
                end
                default: s_nxt.phase = CWU_ST_OFF;
            endcase
        end

        // ahb-lite: capture address phase, act in data phase
        // the slave never inserts wait states, so hreadyout is tied high
        // and every transfer answers okay.
        // writes land at the end of the data phase using hwdata.
        // reads are looked up in the address phase and registered,
        // so hrdata stands during the data phase and is zero otherwise.
        // unmapped offsets read zero and ignore writes.
        // only the low byte of each word is used; hsize is not decoded.
        // the status register is read only and shows live state.
        // a software clear of the shutdown flag is refused while an
        // enabled source is still active.
        if (s_r.bus.pend && s_r.bus.wr) begin
            if (hit(s_r.bus.addr, CWU_CTRL0_OFS)) begin
                s_nxt.ctrl0 = hwdata[7:0] & 8'hF9;
            end
            if (hit(s_r.bus.addr, CWU_CTRL1_OFS)) begin
                s_nxt.ctrl1 = hwdata[7:0] & 8'hF3;
            end
            if (hit(s_r.bus.addr, CWU_CTRL2_OFS)) begin
                s_nxt.ctrl2 = {hwdata[CWU_C2_ARS], hwdata[CWU_C2_FLE], hwdata[CWU_C2_C2E], hwdata[CWU_C2_C1E]};
                // software clear only succeeds with no active source
                if (hwdata[CWU_C2_SDS]) begin
                    s_nxt.sd_stat = 1'b1;
                end else if (!sd_act) begin
                    s_nxt.sd_stat = 1'b0;
                end
            end
            if (hit(s_r.bus.addr, CWU_DBR_OFS)) begin
                s_nxt.dbr = hwdata[5:0];
            end
            if (hit(s_r.bus.addr, CWU_DBF_OFS)) begin
                s_nxt.dbf = hwdata[5:0];
            end
        end
        s_nxt.bus.pend = hsel & hready & htrans[1];
        s_nxt.bus.wr = hwrite;
        s_nxt.bus.addr = haddr[7:0];
        s_nxt.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (hit(haddr[7:0], CWU_CTRL0_OFS)) begin
                s_nxt.rdata[7:0] = s_r.ctrl0;
            end
            if (hit(haddr[7:0], CWU_CTRL1_OFS)) begin
                s_nxt.rdata[7:0] = s_r.ctrl1;
            end
            if (hit(haddr[7:0], CWU_CTRL2_OFS)) begin
                s_nxt.rdata[7:0] = {s_r.sd_stat, s_r.ctrl2[3], 2'b00, s_r.ctrl2[1], s_r.ctrl2[0], s_r.ctrl2[2], 1'b0};
            end
            if (hit(haddr[7:0], CWU_DBR_OFS)) begin
                s_nxt.rdata[5:0] = s_r.dbr;
            end
            if (hit(haddr[7:0], CWU_DBF_OFS)) begin
                s_nxt.rdata[5:0] = s_r.dbf;
            end
            if (hit(haddr[7:0], CWU_STAT_OFS)) begin
                s_nxt.rdata[3:0] = {s_r.hold, sd_act, s_r.drv_b, s_r.drv_a};
            end
        end
        // ctrl2 stored as {ars, flt, c2, c1}: remap index 3=ars,2=flt,1=c2,0=c1
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.ctrl0 <= CWU_CTRL0_RST;
            s_r.ctrl1 <= CWU_CTRL1_RST;
            s_r.dbr <= CWU_DB_RST;
            s_r.dbf <= CWU_DB_RST;
            s_r.phase <= CWU_ST_OFF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    // overrides apply while the status or hold flag is set.
    // fixed high and low overrides ignore polarity entirely.
    // the tri-state override drops the pin enable instead of a level.
    // the inactive override keeps polarity and follows the drive,
    // which keeps following the input, since shutdown does not stop the sequencer.
    // a pin whose enable is low is driven to zero, never left
    // floating inside the block; the pad decides its real level.
    // module enable gates both pin enables, so a disabled block
    // has no effect on either pin whatever the other bits say.
    // pins are combinational from registers only, so they change
    // one edge after the state that decides them.
    assign pa = (s_r.hold || s_r.sd_stat) ?
        ovr_pin(s_r.ctrl1[CWU_C1_LVLA +: 2], s_r.drv_a, s_r.ctrl0[CWU_C0_POLA]) :
        {1'b1, ~(s_r.drv_a ^ s_r.ctrl0[CWU_C0_POLA])};
    assign pb = (s_r.hold || s_r.sd_stat) ?
        ovr_pin(s_r.ctrl1[CWU_C1_LVLB +: 2], s_r.drv_b, s_r.ctrl0[CWU_C0_POLB]) :
        {1'b1, ~(s_r.drv_b ^ s_r.ctrl0[CWU_C0_POLB])};

    // enables gated by module enable
    assign drive_output_a_oe = s_r.ctrl0[CWU_C0_EN] & s_r.ctrl0[CWU_C0_OEA] & pa[1];
    assign drive_output_b_oe = s_r.ctrl0[CWU_C0_EN] & s_r.ctrl0[CWU_C0_OEB] & pb[1];
    assign drive_output_a = drive_output_a_oe & pa[0];
    assign drive_output_b = drive_output_b_oe & pb[0];

    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule

`default_nettype wire

// ===== cwu_pkg.sv
package cwu_pkg;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] CWU_CTRL0_OFS = 8'h00;
    localparam logic [7:0] CWU_CTRL1_OFS = 8'h04;
    localparam logic [7:0] CWU_CTRL2_OFS = 8'h08;
    localparam logic [7:0] CWU_DBR_OFS = 8'h0C;
    localparam logic [7:0] CWU_DBF_OFS = 8'h10;
    localparam logic [7:0] CWU_STAT_OFS = 8'h14;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CWU_C0_EN = 7;
    localparam int CWU_C0_OEB = 6;
    localparam int CWU_C0_OEA = 5;
    localparam int CWU_C0_POLB = 4;
    localparam int CWU_C0_POLA = 3;
    localparam int CWU_C0_CS = 0;
    localparam int CWU_C1_LVLB = 6;
    localparam int CWU_C1_LVLA = 4;
    localparam int CWU_C1_IS = 0;
    localparam int CWU_C2_SDS = 7;
    localparam int CWU_C2_ARS = 6;
    localparam int CWU_C2_C2E = 3;
    localparam int CWU_C2_C1E = 2;
    localparam int CWU_C2_FLE = 1;

    // ----------------------------------------
    // reset values and encodings
    // ----------------------------------------
    localparam logic [7:0] CWU_CTRL0_RST = 8'h00;
    localparam logic [7:0] CWU_CTRL1_RST = 8'h00;
    localparam logic [7:0] CWU_CTRL2_RST = 8'h00;
    localparam logic [5:0] CWU_DB_RST = 6'h00;
    localparam logic [1:0] CWU_LVL_HIGH = 2'h3;
    localparam logic [1:0] CWU_LVL_LOW = 2'h2;
    localparam logic [1:0] CWU_LVL_TRI = 2'h1;
    localparam logic [1:0] CWU_SRC_C2 = 2'h0;
    localparam logic [1:0] CWU_SRC_C1 = 2'h1;
    localparam logic [1:0] CWU_SRC_P1 = 2'h2;
    localparam logic [1:0] CWU_SRC_P2 = 2'h3;
    localparam int CWU_OSC_MHZ = 16;

    typedef enum logic [1:0] {CWU_ST_OFF, CWU_ST_RISE, CWU_ST_FALL} cwu_phase_t;

    // bus slave address-phase capture
    typedef struct packed {
        logic pend;
        logic wr;
        logic [7:0] addr;
    } cwu_bus_t;

    // all module state
    typedef struct packed {
        cwu_bus_t bus;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [3:0] ctrl2; // {auto restart, fault, comparator 2, comparator 1}
        logic sd_stat;
        logic [5:0] dbr;
        logic [5:0] dbf;
        logic [1:0] src_s1;
        logic [1:0] src_s2;
        logic [2:0] sdin_s1;
        logic [2:0] sdin_s2;
        logic osc_s1;
        logic osc_s2;
        logic osc_d;
        logic in_d;
        logic hold;
        cwu_phase_t phase;
        logic [5:0] cnt;
        logic drv_a;
        logic drv_b;
        logic en_d;
        logic [31:0] rdata;
    } cwu_state_t;

endpackage

// ===== cwu_checker.sv
`timescale 1ns/10ps
`default_nettype none

module cwu_checker
    import cwu_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // bus side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // pins
    input wire logic fault_input_pin_n,
    input wire logic drive_output_a,
    input wire logic drive_output_a_oe,
    input wire logic drive_output_b,
    input wire logic drive_output_b_oe
);
    logic dp_v_r;
    logic dp_wr_r;
    logic [7:0] dp_ad_r;
    logic [7:0] c0_r;
    logic [7:0] c1_r;
    logic [7:0] c2_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // shadow copies of the control writes
    // ----------------------------------------
    // address phase capture, gated by dp_v_r
    always_ff @(posedge sys_clk) begin
        if (hready && hsel && htrans[1]) begin
            dp_wr_r <= hwrite;
            dp_ad_r <= haddr[7:0];
        end
    end

    // writes land at the end of the data phase, as in the slave
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dp_v_r <= 1'b0;
            c0_r <= 8'h00;
            c1_r <= 8'h00;
            c2_r <= 8'h00;
        end else begin
            if (hready) begin
                dp_v_r <= hsel & htrans[1];
            end
            if (dp_v_r && dp_wr_r && dp_ad_r == CWU_CTRL0_OFS) begin
                c0_r <= hwdata[7:0];
            end
            if (dp_v_r && dp_wr_r && dp_ad_r == CWU_CTRL1_OFS) begin
                c1_r <= hwdata[7:0];
            end
            if (dp_v_r && dp_wr_r && dp_ad_r == CWU_CTRL2_OFS) begin
                c2_r <= hwdata[7:0];
            end
        end
    end

    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered with an error");
    a_read_idle: assert property (!(dp_v_r && !dp_wr_r) |-> hrdata == 32'h0000_0000)
        else $error("read data driven outside a read data phase");
    a_en_gates_oe: assert property (
        !c0_r[CWU_C0_EN] |-> !drive_output_a_oe && !drive_output_b_oe)
        else $error("pin enabled while the module is off");
    a_oe_gates_pin: assert property (
        (c0_r[CWU_C0_OEA] || !drive_output_a_oe) && (c0_r[CWU_C0_OEB] || !drive_output_b_oe))
        else $error("pin enabled without its own enable bit");
    a_pin_low_off: assert property (
        (drive_output_a_oe || !drive_output_a) && (drive_output_b_oe || !drive_output_b))
        else $error("released pin not low");
    a_start_cleared: assert property (
        $rose(c0_r[CWU_C0_EN]) && c0_r[4:3] == 2'b11 && c1_r[7:4] == 4'h0 |-> !drive_output_a && !drive_output_b)
        else $error("drives not cleared on enable");
    a_no_overlap: assert property (
        c0_r[4:3] == 2'b11 && c1_r[7:4] == 4'h0 |-> !(drive_output_a && drive_output_b))
        else $error("both drives active together");
    a_fault_fast: assert property (
        $fell(fault_input_pin_n) && c2_r[CWU_C2_FLE] && c0_r[CWU_C0_EN] && c0_r[CWU_C0_OEA]
        && c1_r[5:4] == CWU_LVL_LOW |-> ##[1:4] (drive_output_a_oe && !drive_output_a))
        else $error("fault did not force the low override");
    a_sd_holds: assert property (
        (c2_r[7:6] == 2'b10 && c0_r[CWU_C0_EN] && c0_r[CWU_C0_OEA] && c1_r[5:4] == CWU_LVL_HIGH)[*2]
        |-> drive_output_a && drive_output_a_oe)
        else $error("software shutdown not holding the high override");
endmodule

`default_nettype wire

// ===== cwu_switch_stage.sv
`timescale 1ns/10ps
`default_nettype none

module cwu_switch_stage
    import cwu_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // gate drive pins
    input wire logic drive_output_a,
    input wire logic drive_output_a_oe,
    input wire logic drive_output_b,
    input wire logic drive_output_b_oe,
    // cycles with both switches on
    output logic [15:0] overlap_cnt
);
    logic gate_a;
    logic gate_b;

    // a released pin falls to the gate pull-down level
    assign gate_a = drive_output_a_oe & drive_output_a;
    assign gate_b = drive_output_b_oe & drive_output_b;

    // both switches conducting is shoot-through
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            overlap_cnt <= 16'h0000;
        end else if (gate_a && gate_b) begin
            overlap_cnt <= overlap_cnt + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// ===== tb_cwu_complementary_wave_unit.sv
`timescale 1ns/10ps
`default_nettype none

module tb_cwu_complementary_wave_unit import cwu_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [3:0] src_v = 4'h0;
    logic fault_n = 1'b1;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout, hresp, pa, pa_oe, pb, pb_oe, bad;
    logic [15:0] overlap_cnt;
    int n_errors = 0;
    int total_checks = 0;
    int tno = 0;
    int rv[5] = '{0, 1, 5, 63, 7};
    int fv[5] = '{0, 1, 5, 63, 2};

    // system clock and the free-running oscillator
    always #2 sys_clk = ~sys_clk;
    always #31.25 osc = ~osc;

    cwu_complementary_wave_unit cwu_complementary_wave_unit_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .comparator_one_output(src_v[1]), .comparator_two_output(src_v[0]),
        .pulse_unit_one_output(src_v[2]), .pulse_unit_two_output(src_v[3]), .fault_input_pin_n(fault_n),
        .internal_fast_oscillator(osc), .drive_output_a(pa), .drive_output_a_oe(pa_oe),
        .drive_output_b(pb), .drive_output_b_oe(pb_oe));

    cwu_switch_stage cwu_switch_stage_i (.sys_clk(sys_clk), .rst_n(rst_n), .drive_output_a(pa),
        .drive_output_a_oe(pa_oe), .drive_output_b(pb), .drive_output_b_oe(pb_oe), .overlap_cnt(overlap_cnt));

    // ----------------------------------------
    // access and check tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic bail();
        n_errors++;
        print_verdict();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic tend();
        tno++;
        $display("test %0d done, mismatches %0d", tno, n_errors);
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) bail();
            @(posedge sys_clk);
        end
    endtask

    // one single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, {24'h00_0000, e});
    endtask

    // drive an input edge, count cycles from one drive off to the other on
    task automatic gap(input logic lvl, input int lo, input int hi);
        int k;
        src_v <= {4{lvl}};
        k = 0;
        @(posedge sys_clk);
        while ((lvl ? pb : pa) !== 1'b0 && k < 400) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 400) bail();
        k = 0;
        while ((lvl ? pa : pb) !== 1'b1 && k < 400) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 400) bail();
        chk(32'(k >= lo && k <= hi), 32'h1);
    endtask

    task automatic toggle();
        src_v[2] <= 1'b0;
        cyc(10);
        src_v[2] <= 1'b1;
        cyc(10);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 7; i++) begin
            rdc(8'(4 * i), 8'h00);
        end
        tend();
        wr(CWU_CTRL1_OFS, 8'h02);
        wr(CWU_CTRL0_OFS, 8'hF8);
        cyc(1);
        chk(32'({pa, pb, pa_oe, pb_oe}), 32'h3);
        src_v <= 4'hF;
        cyc(80);
        for (int i = 0; i < 5; i++) begin
            wr(CWU_DBR_OFS, 8'(rv[i]));
            wr(CWU_DBF_OFS, 8'(fv[i]));
            gap(1'b0, fv[i], fv[i]);
            gap(1'b1, rv[i], rv[i]);
        end
        wr(CWU_DBF_OFS, 8'h14);
        src_v <= 4'h0;
        cyc(5);
        src_v <= 4'hF;
        bad = 1'b0;
        repeat (40) begin
            @(posedge sys_clk);
            bad = bad | pb;
        end
        chk(32'({bad, pa}), 32'h1);
        tend();
        wr(CWU_DBR_OFS, 8'h02);
        wr(CWU_DBF_OFS, 8'h02);
        wr(CWU_CTRL0_OFS, 8'hF9);
        gap(1'b0, 14, 48);
        gap(1'b1, 14, 48);
        wr(CWU_CTRL0_OFS, 8'hF8);
        wr(CWU_DBR_OFS, 8'h00);
        wr(CWU_DBF_OFS, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(CWU_CTRL1_OFS, 8'(s));
            src_v <= ~(4'h1 << s);
            cyc(10);
            chk(32'({pa, pb}), 32'h1);
            src_v <= 4'h1 << s;
            cyc(10);
            chk(32'({pa, pb}), 32'h2);
        end
        chk(32'(overlap_cnt), 32'h0);
        src_v <= 4'hF;
        tend();
        wr(CWU_CTRL0_OFS, 8'hE0);
        cyc(1);
        chk(32'({pa, pb, pa_oe, pb_oe}), 32'h7);
        wr(CWU_CTRL0_OFS, 8'hC0);
        cyc(1);
        chk(32'({pa_oe, pb_oe}), 32'h1);
        wr(CWU_CTRL0_OFS, 8'h78);
        cyc(1);
        chk(32'({pa, pb, pa_oe, pb_oe}), 32'h0);
        tend();
        wr(CWU_CTRL1_OFS, 8'hB2);
        wr(CWU_CTRL0_OFS, 8'hE0);
        wr(CWU_CTRL2_OFS, 8'h80);
        cyc(2);
        chk(32'({pa, pb, pa_oe, pb_oe}), 32'hB);
        rdc(CWU_CTRL2_OFS, 8'h80);
        wr(CWU_CTRL1_OFS, 8'h52);
        wr(CWU_CTRL2_OFS, 8'h00);
        cyc(10);
        chk(32'({pa_oe, pb_oe}), 32'h0);
        toggle();
        chk(32'({pa, pb, pa_oe, pb_oe}), 32'h7);
        tend();
        wr(CWU_CTRL0_OFS, 8'hF8);
        wr(CWU_CTRL1_OFS, 8'hE2);
        for (int j = 0; j < 3; j++) begin
            wr(CWU_CTRL2_OFS, 8'h40 | (8'h02 << j));
            fault_n <= (j != 0);
            src_v <= {1'b0, 1'b1, j == 1, j == 2};
            cyc(6);
            chk(32'({pa, pb}), 32'h1);
            wr(CWU_CTRL2_OFS, 8'h40 | (8'h02 << j));
            rdc(CWU_CTRL2_OFS, 8'hC0 | (8'h02 << j));
            fault_n <= 1'b1;
            src_v <= 4'h4;
            cyc(5);
            toggle();
            toggle();
            rdc(CWU_CTRL2_OFS, 8'h40 | (8'h02 << j));
            chk(32'({pa, pb}), 32'h2);
        end
        tend();
        print_verdict();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        bail();
    end
endmodule

bind cwu_complementary_wave_unit cwu_checker cwu_checker_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fault_input_pin_n(fault_input_pin_n), .drive_output_a(drive_output_a),
    .drive_output_a_oe(drive_output_a_oe), .drive_output_b(drive_output_b), .drive_output_b_oe(drive_output_b_oe));

`default_nettype wire
